// ### src/pwr_seq_cfg.svh
// Purpose: timing counts and counter width for the core regulator power sequencer
// Assumes: core clock at 40 MHz (25 ns period)
// Notes: times kept in their printed unit, cycle counts derived from them
`ifndef PWR_SEQ_CFG_SVH
`define PWR_SEQ_CFG_SVH

`define CLK_PERIOD_NS 25
`define PG_TIMEOUT_MS 1000
`define PG_TIMEOUT_CYC ((`PG_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`define VALID_LOW_MS 1
`define VALID_LOW_CYC ((`VALID_LOW_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_HOLD_MS 6
`define RESET_HOLD_CYC ((`RESET_HOLD_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 26

`endif

// ### src/pwr_seq_pkg.sv
// Purpose: types shared by the power sequencer files
// Assumes: nothing beyond the cfg header
// Notes: state codes written out
package pwr_seq_pkg;
    typedef enum logic [2:0] {
        ST_OFF     = 3'h0,
        ST_WAIT_PG = 3'h1,
        ST_RESET   = 3'h2,
        ST_RUN     = 3'h3,
        ST_FAULT   = 3'h4
    } seq_state_e;

    typedef struct packed {
        logic dc_good;
        logic v5_good;
        logic v3_good;
        logic v3s_good;
    } rails_s;

    typedef struct packed {
        logic [25:0] cnt;
        logic done;
    } timer_s;
endpackage

// ### src/seq_timer.sv
// Purpose: down counter that flags when a loaded interval has elapsed
// Assumes: synchronous active-low reset
// Notes: load restarts the count; done holds until the next load
module seq_timer (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // control
    input wire logic i_load,
    input wire logic [25:0] i_count,
    // status
    output logic o_done
);
    pwr_seq_pkg::timer_s st_q, st_d;

    always_comb begin
        st_d = st_q;
        if (i_load) begin
            st_d.cnt = i_count;
            st_d.done = 1'b0;
        end else if (st_q.cnt != 26'h0) begin
            st_d.cnt = st_q.cnt - 26'h1;
        end else begin
            st_d.done = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_done = st_q.done;
endmodule // seq_timer

// ### src/rail_qual.sv
// Purpose: forms the combined rail conditions used by the sequencer
// Assumes: rail-good inputs are synchronous levels
// Notes: registered so decisions use one consistent sample
module rail_qual (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // rails
    input pwr_seq_pkg::rails_s i_rails,
    // results
    output logic o_turn_on_ok,
    output logic o_v3s_good
);
    logic [1:0] q_q, q_d;

    always_comb begin
        q_d = {i_rails.dc_good & i_rails.v5_good & i_rails.v3_good, i_rails.v3s_good};
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            q_q <= 2'h0;
        end else begin
            q_q <= q_d;
        end
    end

    assign o_turn_on_ok = q_q[1];
    assign o_v3s_good = q_q[0];
endmodule // rail_qual

// ### src/core_regulator_power_sequencer.sv
// Purpose: system-side controller that sequences the core regulator and processor reset
// Assumes: all inputs synchronous to i_core_clk; rail-good levels come from comparators
// Notes: the regulator's own behaviour is outside; this block only drives and watches its pins
`include "pwr_seq_cfg.svh"

module core_regulator_power_sequencer #(
    parameter logic [25:0] PG_TIMEOUT_CYC = 26'(`PG_TIMEOUT_CYC),
    parameter logic [25:0] VALID_LOW_CYC = 26'(`VALID_LOW_CYC),
    parameter logic [25:0] RESET_HOLD_CYC = 26'(`RESET_HOLD_CYC)
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // rail good indications
    input pwr_seq_pkg::rails_s i_rails,
    // power management controls
    input wire logic i_suspend_b_control,
    input wire logic i_resume_well_reset_n,
    input wire logic i_cpu_clock_halt_n,
    // regulator pins
    input wire logic i_regulator_power_good,
    output logic o_regulator_enable,
    // system outputs
    output logic o_system_power_ok,
    output logic o_processor_reset,
    output logic o_clock_gen_halt_n,
    output logic o_core_speed_select,
    output logic o_pg_timeout
);
    typedef struct packed {
        pwr_seq_pkg::seq_state_e state;
        logic en;
        logic pok;
        logic rst;
        logic halt_n;
        logic spd;
        logic tmo;
        logic low_met;
    } state_s;

    state_s s_q, s_d;
    logic turn_on_ok, v3s_good;
    logic ld_tmo, ld_low, ld_rst;
    logic tmo_done, low_done, rst_done;
    logic want_on;
    logic first_q;

    rail_qual u_rail (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_rails(i_rails),
        .o_turn_on_ok(turn_on_ok),
        .o_v3s_good(v3s_good)
    );

    // one timer per interval keeps each count independent of the others
    seq_timer u_tmo (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_load(ld_tmo),
        .i_count(PG_TIMEOUT_CYC),
        .o_done(tmo_done)
    );

    seq_timer u_low (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_load(ld_low),
        .i_count(VALID_LOW_CYC),
        .o_done(low_done)
    );

    seq_timer u_rst (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_load(ld_rst),
        .i_count(RESET_HOLD_CYC),
        .o_done(rst_done)
    );

    // the enable request follows suspend control; power good is only ever sampled here
    assign want_on = i_suspend_b_control;

    always_comb begin
        s_d = s_q;
        ld_tmo = 1'b0;
        ld_low = 1'b0;
        ld_rst = 1'b0;
        s_d.halt_n = i_resume_well_reset_n & i_suspend_b_control;
        // speed select driven high before and across the enable edge
        s_d.spd = 1'b1;
        if (low_done) begin
            s_d.low_met = 1'b1;
        end
        // a fresh reset counts as a turn-off, so the very first turn-on
        // also waits out the valid-low time
        if (first_q) begin
            ld_low = 1'b1;
        end
        case (s_q.state)
            pwr_seq_pkg::ST_OFF: begin
                s_d.en = 1'b0;
                s_d.pok = 1'b0;
                s_d.rst = 1'b1;
                // rails checked afresh and valid low time met on every turn-on
                if (want_on && turn_on_ok && s_q.low_met) begin
                    s_d.en = 1'b1;
                    s_d.tmo = 1'b0;
                    s_d.state = pwr_seq_pkg::ST_WAIT_PG;
                    ld_tmo = 1'b1;
                end
            end
            pwr_seq_pkg::ST_WAIT_PG: begin
                if (!want_on || !turn_on_ok) begin
                    s_d.en = 1'b0;
                    s_d.low_met = 1'b0;
                    ld_low = 1'b1;
                    s_d.state = pwr_seq_pkg::ST_OFF;
                end else if (i_regulator_power_good) begin
                    s_d.state = pwr_seq_pkg::ST_RESET;
                end else if (tmo_done) begin
                    s_d.en = 1'b0;
                    s_d.tmo = 1'b1;
                    s_d.low_met = 1'b0;
                    ld_low = 1'b1;
                    s_d.state = pwr_seq_pkg::ST_FAULT;
                end
            end
            pwr_seq_pkg::ST_RESET: begin
                // power ok only while power good already seen high
                s_d.pok = i_regulator_power_good & v3s_good;
                if (!s_d.pok || !s_q.pok || !i_cpu_clock_halt_n || !s_d.halt_n) begin
                    ld_rst = 1'b1;
                end
                if (!want_on || !turn_on_ok) begin
                    s_d.en = 1'b0;
                    s_d.pok = 1'b0;
                    s_d.low_met = 1'b0;
                    ld_low = 1'b1;
                    s_d.state = pwr_seq_pkg::ST_OFF;
                end else if (!ld_rst && rst_done) begin
                    // a hold restart in this same cycle wins over the release
                    s_d.rst = 1'b0;
                    s_d.state = pwr_seq_pkg::ST_RUN;
                end
            end
            pwr_seq_pkg::ST_RUN: begin
                s_d.pok = i_regulator_power_good & v3s_good;
                if (!want_on || !turn_on_ok) begin
                    s_d.en = 1'b0;
                    s_d.pok = 1'b0;
                    s_d.rst = 1'b1;
                    s_d.low_met = 1'b0;
                    ld_low = 1'b1;
                    s_d.state = pwr_seq_pkg::ST_OFF;
                end else if (!s_d.pok || !i_cpu_clock_halt_n || !s_d.halt_n) begin
                    s_d.rst = 1'b1;
                    ld_rst = 1'b1;
                    s_d.state = pwr_seq_pkg::ST_RESET;
                end
            end
            pwr_seq_pkg::ST_FAULT: begin
                // retry needs suspend control cycled low so a dead regulator is not hammered
                s_d.en = 1'b0;
                if (!want_on) begin
                    s_d.state = pwr_seq_pkg::ST_OFF;
                end
            end
            default: begin
                s_d.state = pwr_seq_pkg::ST_OFF;
                s_d.en = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            s_q <= '{state: pwr_seq_pkg::ST_OFF, en: 1'b0, pok: 1'b0, rst: 1'b1,
                     halt_n: 1'b0, spd: 1'b1, tmo: 1'b0, low_met: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // the first valid-low interval starts at reset release
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    assign o_regulator_enable = s_q.en;
    assign o_system_power_ok = s_q.pok;
    assign o_processor_reset = s_q.rst;
    assign o_clock_gen_halt_n = s_q.halt_n;
    assign o_core_speed_select = s_q.spd;
    assign o_pg_timeout = s_q.tmo;

    logic [25:0] low_cnt_q;
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            low_cnt_q <= 26'h0;
        end else if (s_q.en) begin
            low_cnt_q <= 26'h0;
        end else if (low_cnt_q != 26'h3FFFFFF) begin
            low_cnt_q <= low_cnt_q + 26'h1;
        end
    end

    // cycles spent waiting for power good, held against the one-second limit;
    // a timeout that fires early would cut off a slow but healthy regulator
    logic [25:0] wait_cnt_q;
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst || s_q.state != pwr_seq_pkg::ST_WAIT_PG) begin
            wait_cnt_q <= 26'h0;
        end else begin
            wait_cnt_q <= wait_cnt_q + 26'h1;
        end
    end

    // cycles of reset with power ok up and both halts inactive
    logic [25:0] hold_cnt_q;
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst || !o_system_power_ok || !o_processor_reset || !i_cpu_clock_halt_n
            || !(i_resume_well_reset_n && i_suspend_b_control)) begin
            hold_cnt_q <= 26'h0;
        end else if (hold_cnt_q != 26'h3FFFFFF) begin
            hold_cnt_q <= hold_cnt_q + 26'h1;
        end
    end

    power_ok_gated_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        o_system_power_ok |-> $past(i_regulator_power_good) && $past(v3s_good))
        else $error("power ok without power good and 3v3");
    power_ok_after_pg_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        $rose(o_system_power_ok) |-> $past(i_regulator_power_good))
        else $error("power ok rose before power good");
    enable_rails_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        $rose(o_regulator_enable) |-> $past(turn_on_ok) && $past(want_on))
        else $error("enable raised without rails good");
    valid_low_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        $rose(o_regulator_enable) |-> $past(low_cnt_q) >= VALID_LOW_CYC)
        else $error("enable low time too short");
    timeout_drop_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        $rose(o_pg_timeout) |-> !o_regulator_enable)
        else $error("enable kept after power good timeout");
    halt_and_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        ##1 o_clock_gen_halt_n == ($past(i_resume_well_reset_n) && $past(i_suspend_b_control)))
        else $error("clock halt not the AND of its inputs");
    speed_at_enable_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        $rose(o_regulator_enable) |-> o_core_speed_select && $past(o_core_speed_select))
        else $error("speed select low at enable edge");
    reset_release_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        $fell(o_processor_reset) |-> $past(o_system_power_ok, 2) && o_system_power_ok)
        else $error("reset released without power ok held");
    pg_loss_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (s_q.state == pwr_seq_pkg::ST_RUN && !i_regulator_power_good && want_on && turn_on_ok)
        |=> o_processor_reset && !o_system_power_ok)
        else $error("power good loss did not reset");
    off_first_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst || first_q)
        (s_q.en && !want_on) |=> !o_regulator_enable)
        else $error("enable not dropped on suspend");

    // power ok and a released reset only ever stand inside an enabled window
    ok_needs_enable_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        o_system_power_ok |-> o_regulator_enable)
        else $error("power ok while regulator disabled");
    reset_without_ok_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        !o_system_power_ok |-> o_processor_reset)
        else $error("processor reset released without power ok");
    timeout_not_early_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        $rose(o_pg_timeout) |-> $past(wait_cnt_q) >= PG_TIMEOUT_CYC)
        else $error("power good timeout fired early");
    wait_bounded_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        wait_cnt_q <= PG_TIMEOUT_CYC + 26'h2)
        else $error("power good wait exceeded the limit");
    reset_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        $fell(o_processor_reset) |-> $past(hold_cnt_q) >= RESET_HOLD_CYC)
        else $error("processor reset hold too short");
    fault_stays_off_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (s_q.state == pwr_seq_pkg::ST_FAULT && want_on) |=> !o_regulator_enable)
        else $error("enable retried after timeout");
endmodule // core_regulator_power_sequencer

// ### verification/reg_module_model.sv
// Purpose: behavioural core regulator module answering the enable pin with power good
// Assumes: settle time comes in core clock cycles and is capped at the scaled 6 ms bound
// Notes: stuck keeps power good low while it is set; sag pulls the supply out of regulation
module reg_module_model #(
    parameter logic [15:0] SETTLE_MAX = 16'h0078
) (
    // bench controls
    input wire logic i_core_clk,
    input wire logic [15:0] i_settle,
    input wire logic i_stuck,
    input wire logic i_sag,
    // regulator pins
    input wire logic i_regulator_enable,
    output logic o_regulator_power_good
);
    timeunit 1ns;
    timeprecision 100ps;
    logic supply_on = 1'b0;
    logic [15:0] settle_cnt = 16'h0000;
    logic [15:0] limit;
    assign limit = (i_settle > SETTLE_MAX) ? SETTLE_MAX : i_settle;
    always @(posedge i_core_clk) begin
        supply_on <= i_regulator_enable;
        if (!i_regulator_enable || i_sag) begin
            settle_cnt <= 16'h0000;
        end else if (settle_cnt != 16'hFFFF) begin
            settle_cnt <= settle_cnt + 16'h0001;
        end
    end
    // no pull-up: power good is low whenever the core supply is not settled
    assign o_regulator_power_good = supply_on && !i_stuck && !i_sag
        && (settle_cnt >= limit);
endmodule // reg_module_model

// ### verification/tb.sv
// Purpose: self-checking bench for the core regulator power sequencer
// Assumes: shortened counts: timeout 200, valid-low 20, reset hold 30 cycles
// Notes: a monitor checks enable rises, reset hold and clock halt on every edge
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int VALID = 20;
    localparam int HOLD = 30;
    logic clk, nrst, susp, rsm_n, cpu_halt_n, pg, en, ok, rst, halt_n, spd, tmo, stuck, sag;
    logic en_p, rst_p, ok_p, susp_p, rsm_p, nrst_p;
    logic [15:0] settle;
    pwr_seq_pkg::rails_s rails;
    int failures, check_count, cyc, low_cnt, hold_cnt, idx;

    core_regulator_power_sequencer #(.PG_TIMEOUT_CYC(26'h00000C8),
        .VALID_LOW_CYC(26'h0000014), .RESET_HOLD_CYC(26'h000001E)) DUT (
        .i_core_clk(clk), .i_nrst(nrst), .i_rails(rails), .i_suspend_b_control(susp),
        .i_resume_well_reset_n(rsm_n), .i_cpu_clock_halt_n(cpu_halt_n),
        .i_regulator_power_good(pg), .o_regulator_enable(en), .o_system_power_ok(ok),
        .o_processor_reset(rst), .o_clock_gen_halt_n(halt_n), .o_core_speed_select(spd),
        .o_pg_timeout(tmo));
    reg_module_model model (.i_core_clk(clk), .i_settle(settle), .i_stuck(stuck),
        .i_sag(sag), .i_regulator_enable(en), .o_regulator_power_good(pg));

    always #12.5 clk = ~clk;

    task automatic chk(input string nm, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %b seen %b", nm, exp, got);
        end
    endtask

    function automatic logic exp_halt(input logic rsm, input logic sus);
        return rsm & sus;
    endfunction

    function automatic logic rails_ok(input pwr_seq_pkg::rails_s r);
        return r.dc_good & r.v5_good & r.v3_good;
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            failures++;
            print_verdict();
        end
        if (!nrst) begin
            low_cnt = 0;
            hold_cnt = 0;
        end else begin
            if (en && !en_p) begin
                chk("enable_low_time", 1'b1, low_cnt >= VALID);
                chk("rails_at_enable", 1'b1, rails_ok(rails));
                chk("speed_at_enable", 1'b1, spd);
            end
            if (ok && !ok_p) begin
                chk("power_good_at_ok", 1'b1, pg);
                chk("v3s_at_ok", 1'b1, rails.v3s_good);
            end
            if (rst_p && !rst) chk("reset_hold", 1'b1, hold_cnt >= HOLD);
            if (nrst_p) chk("clock_gen_halt", exp_halt(rsm_p, susp_p), halt_n);
            low_cnt = en ? 0 : low_cnt + 1;
            if (!ok || !cpu_halt_n || !halt_n) hold_cnt = 0;
            else if (rst) hold_cnt++;
        end
        {en_p, rst_p, ok_p, susp_p, rsm_p, nrst_p} = {en, rst, ok, susp, rsm_n, nrst};
    end

    initial begin
        {clk, nrst, susp, rsm_n, stuck, sag} = '0;
        cpu_halt_n = 1'b1;
        rails = '0;
        settle = 16'h0005;
        void'($urandom(56648));
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        chk("enable_reset", 1'b0, en);
        chk("ok_reset", 1'b0, ok);
        chk("cpu_reset_reset", 1'b1, rst);
        chk("timeout_reset", 1'b0, tmo);
        rails.dc_good = 1'b1;
        @(negedge clk);
        {rails.v5_good, rails.v3_good, rails.v3s_good, rsm_n} = 4'hF;
        for (int i = 0; i < 4; i++) begin
            settle = (i == 0) ? 16'h0001 : (i == 3) ? 16'h0078 : 16'($urandom_range(2, 60));
            susp = 1'b1;
            repeat (VALID + 10) if (en !== 1'b1) @(negedge clk);
            chk("enable_on", 1'b1, en);
            repeat (130) if (ok !== 1'b1) @(negedge clk);
            chk("ok_on", 1'b1, ok);
            if (i[0]) begin
                // either halt input held active restarts the reset hold
                {cpu_halt_n, rsm_n} = (i == 1) ? 2'h1 : 2'h2;
                repeat (3) @(negedge clk);
                {cpu_halt_n, rsm_n} = 2'h3;
            end
            repeat (HOLD + 10) if (rst !== 1'b0) @(negedge clk);
            chk("cpu_reset_off", 1'b0, rst);
            if (i[0]) begin
                sag = 1'b1;
                repeat (3) @(negedge clk);
                chk("ok_on_sag", 1'b0, ok);
                chk("cpu_reset_on_sag", 1'b1, rst);
                sag = 1'b0;
                repeat (HOLD + 150) if (rst !== 1'b0) @(negedge clk);
                chk("cpu_reset_after_sag", 1'b0, rst);
            end
            if (i == 2) begin
                rails.v3s_good = 1'b0;
                repeat (3) @(negedge clk);
                chk("ok_v3s_low", 1'b0, ok);
                chk("cpu_reset_v3s_low", 1'b1, rst);
                rails.v3s_good = 1'b1;
            end
            susp = 1'b0;
            repeat (3) @(negedge clk);
            chk("enable_off", 1'b0, en);
            chk("ok_off", 1'b0, ok);
        end
        // one rail short: the request must be refused
        idx = $urandom_range(1, 3);
        rails[idx] = 1'b0;
        susp = 1'b1;
        repeat (60) @(negedge clk);
        chk("enable_rail_bad", 1'b0, en);
        rails[idx] = 1'b1;
        repeat (30) if (en !== 1'b1) @(negedge clk);
        chk("enable_rail_back", 1'b1, en);
        susp = 1'b0;
        stuck = 1'b1;
        repeat (3) @(negedge clk);
        susp = 1'b1;
        repeat (40) if (en !== 1'b1) @(negedge clk);
        repeat (230) if (en !== 1'b0) @(negedge clk);
        chk("enable_timeout", 1'b0, en);
        chk("timeout_flag", 1'b1, tmo);
        repeat (40) @(negedge clk);
        chk("enable_stays_off", 1'b0, en);
        {susp, stuck} = 2'h0;
        repeat (3) @(negedge clk);
        susp = 1'b1;
        repeat (150) if (ok !== 1'b1) @(negedge clk);
        chk("ok_after_timeout", 1'b1, ok);
        chk("timeout_cleared", 1'b0, tmo);
        print_verdict();
    end
endmodule // tb
